// ==== include/ccu_pkg.sv ====
// Purpose: Constants for the CRC instruction execution unit
// Assumes: 32-bit general registers, instruction word given whole
// Notes: Generator constants are reversed, LSB-first
`default_nettype none
package ccu_pkg;
  localparam int unsigned CCU_XLEN = 32;
  localparam logic [31:0] CCU_POLY_CASTAGNOLI = 32'h82f63b78;
  localparam logic [31:0] CCU_POLY_ETHERNET = 32'hedb88320;
  localparam logic [5:0] CCU_MAJOR_GROUP_THREE = 6'h1f;
  localparam logic [5:0] CCU_FUNC_CRC = 6'h0f;
  localparam logic [4:0] CCU_ZERO_FIELD = 5'h00;
  localparam logic [2:0] CCU_VARIANT_ETHERNET = 3'h0;
  localparam logic [2:0] CCU_VARIANT_CASTAGNOLI = 3'h1;
  localparam int unsigned CCU_MAJOR_HI = 31;
  localparam int unsigned CCU_MAJOR_LO = 26;
  localparam int unsigned CCU_ZERO_HI = 15;
  localparam int unsigned CCU_ZERO_LO = 11;
  localparam int unsigned CCU_VAR_HI = 10;
  localparam int unsigned CCU_VAR_LO = 8;
  localparam int unsigned CCU_SIZE_HI = 7;
  localparam int unsigned CCU_SIZE_LO = 6;
  localparam int unsigned CCU_FUNC_HI = 5;
  localparam int unsigned CCU_FUNC_LO = 0;
  typedef enum logic [1:0] {
    CCU_SIZE_BYTE = 2'b00,
    CCU_SIZE_HALF = 2'b01,
    CCU_SIZE_WORD = 2'b10,
    CCU_SIZE_RSVD = 2'b11
  } ccu_size_t;
endpackage
`default_nettype wire

// ==== rtl/ccu_fold.sv ====
// Purpose: Combinational CRC fold of a byte, half-word or word
// Assumes: Message right-justified, upper bits ignored
// Notes: All bit iterations unrolled in one cycle
`default_nettype none
module ccu_fold
  import ccu_pkg::*;
(
  input wire logic [31:0] crc_in,
  input wire logic [31:0] message,
  input wire logic [31:0] poly,
  input wire ccu_pkg::ccu_size_t size,
  output logic [31:0] crc_out
);
  // -----------------------------
  // One LSB-first bit step
  // -----------------------------
  function automatic logic [31:0] ccu_step(input logic [31:0] v, input logic [31:0] p);
    ccu_step = v[0] ? ((v >> 1) ^ p) : (v >> 1);
  endfunction

  // Fold n bytes; wider fold equals successive byte folds
  function automatic logic [31:0] ccu_fold_bytes(input logic [31:0] v, input logic [31:0] p,
                                                 input int unsigned n);
    logic [31:0] acc;
    acc = v;
    for (int i = 0; i < 32; i++) begin
      if (i < n * 8) begin
        acc = ccu_step(acc, p);
      end
    end
    ccu_fold_bytes = acc;
  endfunction

  always_comb begin
    crc_out = crc_in;
    unique case (size)
      CCU_SIZE_BYTE: crc_out = ccu_fold_bytes(crc_in ^ {24'h000000, message[7:0]}, poly, 1);
      CCU_SIZE_HALF: crc_out = ccu_fold_bytes(crc_in ^ {16'h0000, message[15:0]}, poly, 2);
      CCU_SIZE_WORD: crc_out = ccu_fold_bytes(crc_in ^ message, poly, 4);
      CCU_SIZE_RSVD: crc_out = crc_in;
    endcase
  end
endmodule
`default_nettype wire

// ==== rtl/ccu_unit.sv ====
// Behaviour
// - Castagnoli variant computes 32-bit CRC with reversed constant 0x82F63B78.
// - Generator is degree 32; top term dropped, low coefficients in 32 bits.
// - Running CRC from accumulator operand, message right-justified in source operand.
// - New CRC replaces accumulator register contents.
// - Size 00 byte, 01 half-word, 10 word from low end.
// - Size 11 raises reserved-instruction exception, no accumulator update.
// - Presence flag clear makes every group instruction a reserved-instruction exception; unit traps only variants 000 and 001, others give no answer.
// - Running CRC XORed with zero-extended message bits before iterations.
// - Per bit: shift right, XOR generator if old bit 0 set.
// - LSB of each element is highest-order coefficient (LSB-first).
// - No exceptions depend on operand values.
// - Wide element equals its bytes folded in sequence.
// - Decode major 011111, function 001111, bits 15..11 zero, variant 001.
// - Variant 000 uses 0xEDB88320, otherwise identical.
//
// Purpose: Execution unit for the CRC instruction group
// Assumes: Pipeline presents decoded word and operands with in_valid
// Notes: Non-group words with in_valid produce no answer
`default_nettype none
module ccu_unit
  import ccu_pkg::*;
#(
  parameter int unsigned XLEN = CCU_XLEN
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [31:0] instr_word,
  input wire logic [XLEN-1:0] message_source_operand,
  input wire logic [XLEN-1:0] crc_accumulator_operand,
  input wire logic [4:0] accumulator_index,
  input wire logic crc_presence_flag,
  output logic result_valid,
  output logic [XLEN-1:0] result_crc,
  output logic [4:0] writeback_index,
  output logic reserved_instruction
);
  // -----------------------------
  // Answer kinds
  // -----------------------------
  typedef enum logic [1:0] {
    CCU_ANSWER_NONE = 2'b00,
    CCU_ANSWER_GOOD = 2'b01,
    CCU_ANSWER_TRAP = 2'b10
  } ccu_answer_t;

  // -----------------------------
  // Field extraction
  // -----------------------------
  function automatic logic [5:0] ccu_major_of(input logic [31:0] word);
    ccu_major_of = word[CCU_MAJOR_HI:CCU_MAJOR_LO];
  endfunction

  function automatic logic [5:0] ccu_func_of(input logic [31:0] word);
    ccu_func_of = word[CCU_FUNC_HI:CCU_FUNC_LO];
  endfunction

  function automatic logic [4:0] ccu_zero_of(input logic [31:0] word);
    ccu_zero_of = word[CCU_ZERO_HI:CCU_ZERO_LO];
  endfunction

  function automatic logic [2:0] ccu_variant_of(input logic [31:0] word);
    ccu_variant_of = word[CCU_VAR_HI:CCU_VAR_LO];
  endfunction

  function automatic ccu_size_t ccu_size_of(input logic [31:0] word);
    ccu_size_of = ccu_size_t'(word[CCU_SIZE_HI:CCU_SIZE_LO]);
  endfunction

  // -----------------------------
  // Group recognition
  // -----------------------------
  function automatic logic ccu_is_group(input logic [31:0] word);
    logic major_ok;
    logic func_ok;
    logic zero_ok;
    major_ok = (ccu_major_of(word) == CCU_MAJOR_GROUP_THREE);
    func_ok = (ccu_func_of(word) == CCU_FUNC_CRC);
    zero_ok = (ccu_zero_of(word) == CCU_ZERO_FIELD);
    ccu_is_group = major_ok && func_ok && zero_ok;
  endfunction

  // Group word carrying one particular variant code
  function automatic logic ccu_is_variant(input logic [31:0] word, input logic [2:0] code);
    logic code_ok;
    code_ok = (ccu_variant_of(word) == code);
    ccu_is_variant = ccu_is_group(word) && code_ok;
  endfunction

  function automatic logic [31:0] ccu_poly_of(input logic castagnoli);
    logic [31:0] poly_pick;
    poly_pick = CCU_POLY_ETHERNET;
    if (castagnoli) begin
      poly_pick = CCU_POLY_CASTAGNOLI;
    end
    ccu_poly_of = poly_pick;
  endfunction

  // -----------------------------
  // Exception decision
  // -----------------------------
  function automatic logic ccu_size_legal(input ccu_size_t size);
    logic legal;
    legal = 1'b0;
    unique case (size)
      CCU_SIZE_BYTE: legal = 1'b1;
      CCU_SIZE_HALF: legal = 1'b1;
      CCU_SIZE_WORD: legal = 1'b1;
      CCU_SIZE_RSVD: legal = 1'b0;
    endcase
    ccu_size_legal = legal;
  endfunction

  // Only presence flag and size code can trap; operands never do
  function automatic ccu_answer_t ccu_classify(input logic valid, input logic known,
                                               input logic present, input ccu_size_t size);
    ccu_answer_t kind;
    kind = CCU_ANSWER_NONE;
    if (valid && known) begin
      if (!present) begin
        kind = CCU_ANSWER_TRAP;
      end else if (!ccu_size_legal(size)) begin
        kind = CCU_ANSWER_TRAP;
      end else begin
        kind = CCU_ANSWER_GOOD;
      end
    end
    ccu_classify = kind;
  endfunction

  // -----------------------------
  // Decode
  // -----------------------------
  logic is_castagnoli;
  logic is_ethernet;
  logic is_known;
  logic [31:0] poly;
  ccu_size_t message_size_field;
  ccu_answer_t answer_kind;

  always_comb begin
    is_castagnoli = ccu_is_variant(instr_word, CCU_VARIANT_CASTAGNOLI);
    is_ethernet = ccu_is_variant(instr_word, CCU_VARIANT_ETHERNET);
    is_known = is_castagnoli || is_ethernet;
    poly = ccu_poly_of(is_castagnoli);
    message_size_field = ccu_size_of(instr_word);
    answer_kind = ccu_classify(in_valid, is_known, crc_presence_flag, message_size_field);
  end

  // -----------------------------
  // Operands
  // -----------------------------
  logic [31:0] crc_seed;
  logic [31:0] message_bits;

  always_comb begin
    crc_seed = crc_accumulator_operand[31:0];
    message_bits = message_source_operand[31:0];
  end

  // -----------------------------
  // Datapath
  // -----------------------------
  logic [31:0] folded;

  ccu_fold u_fold (
    .crc_in(crc_seed),
    .message(message_bits),
    .poly(poly),
    .size(message_size_field),
    .crc_out(folded)
  );

  // -----------------------------
  // Answer strobes
  // -----------------------------
  logic next_result_valid;
  logic next_reserved_instruction;

  // Trap and result never share a cycle
  always_comb begin
    next_result_valid = 1'b0;
    next_reserved_instruction = 1'b0;
    unique case (answer_kind)
      CCU_ANSWER_NONE: begin
        next_result_valid = 1'b0;
      end
      CCU_ANSWER_GOOD: begin
        next_result_valid = 1'b1;
      end
      CCU_ANSWER_TRAP: begin
        next_reserved_instruction = 1'b1;
      end
      default: begin
        next_result_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result_valid <= 1'b0;
      reserved_instruction <= 1'b0;
    end else begin
      result_valid <= next_result_valid;
      reserved_instruction <= next_reserved_instruction;
    end
  end

  // -----------------------------
  // Answer data
  // -----------------------------
  logic [XLEN-1:0] next_result_crc;
  logic [4:0] next_writeback_index;

  // Data holds on traps so the accumulator is never overwritten
  always_comb begin
    next_result_crc = result_crc;
    next_writeback_index = writeback_index;
    unique case (answer_kind)
      CCU_ANSWER_NONE: begin
        next_result_crc = result_crc;
      end
      CCU_ANSWER_GOOD: begin
        next_result_crc = XLEN'(folded);
        next_writeback_index = accumulator_index;
      end
      CCU_ANSWER_TRAP: begin
        next_result_crc = result_crc;
      end
      default: begin
        next_result_crc = result_crc;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result_crc <= '0;
      writeback_index <= '0;
    end else begin
      result_crc <= next_result_crc;
      writeback_index <= next_writeback_index;
    end
  end
endmodule
`default_nettype wire

// ==== bench/ccu_unit_assertions.sv ====
// Purpose: Port checks for ccu_unit
// Assumes: One clock, async reset
// Notes: Bound from the bench top
`default_nettype none
module ccu_unit_assertions (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] message_source_operand,
  input wire logic [31:0] crc_accumulator_operand,
  input wire logic [4:0] accumulator_index,
  input wire logic crc_presence_flag,
  input wire logic result_valid,
  input wire logic [31:0] result_crc,
  input wire logic [4:0] writeback_index,
  input wire logic reserved_instruction
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire grp = in_valid && instr_word[31:26] == 6'h1f && instr_word[15:9] == 7'h00
    && instr_word[5:0] == 6'h0f;
  wire rsz = instr_word[7:6] == 2'b11;
  sequence s_take; grp && crc_presence_flag && !rsz; endsequence
  sequence s_trap; reserved_instruction && !result_valid; endsequence
  a_size_trap: assert property (grp && crc_presence_flag && rsz |=> s_trap)
    else $error("size trap");
  a_flag_trap: assert property (grp && !crc_presence_flag |=> s_trap)
    else $error("flag trap");
  a_good_result: assert property (s_take |=> result_valid && !reserved_instruction)
    else $error("no result");
  a_index_echo: assert property (s_take |=> writeback_index == $past(accumulator_index))
    else $error("index");
  a_no_answer: assert property (!grp |=> !result_valid && !reserved_instruction)
    else $error("stray answer");
  a_crc_hold: assert property (!result_valid |-> $stable(result_crc))
    else $error("crc moved");
  a_one_kind: assert property (!(result_valid && reserved_instruction))
    else $error("both");
  a_poly_pick: assert property (s_take and (crc_accumulator_operand == 0
    && message_source_operand == 32'h80 && instr_word[7:6] == 2'b00) |=> result_crc ==
    ($past(instr_word[8]) ? 32'h82f63b78 : 32'hedb88320)) else $error("poly");
endmodule
`default_nettype wire

// ==== bench/ccu_pipe_model.sv ====
// Purpose: Pipeline side that builds group words
// Assumes: Fields come from the bench
// Notes: bad_func spoils the function code
`default_nettype none
module ccu_pipe_model (
  input wire logic variant,
  input wire logic [1:0] size,
  input wire logic bad_func,
  input wire logic [9:0] regs,
  output logic [31:0] instr_word
);
  import ccu_pkg::*;
  assign instr_word = {CCU_MAJOR_GROUP_THREE, regs, CCU_ZERO_FIELD, 2'b00, variant, size,
    bad_func ? 6'h0e : CCU_FUNC_CRC};
endmodule
`default_nettype wire

// ==== bench/ccu_unit_bench.sv ====
// Purpose: Random and corner tests of ccu_unit
// Assumes: Answer one cycle after issue
// Notes: Expected CRC from a bitwise model
`default_nettype none
module ccu_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ccu_pkg::*;
  logic clock = 0, arst_n = 0, in_valid = 0, flag = 1, variant = 1, bad = 0;
  logic [1:0] size = 0;
  logic [9:0] regs = 0;
  logic [4:0] idx = 0, writeback_index;
  logic [31:0] instr_word, msg = 0, acc = 0, last = 0, got, chain, result_crc;
  logic result_valid, reserved_instruction;
  int failures = 0, compares = 0, seed = 32'h59aa;
  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("BAD %0t mismatch", $time); end end
  always #25 clock = ~clock;
  ccu_pipe_model pipe (.variant(variant), .size(size), .bad_func(bad), .regs(regs),
    .instr_word(instr_word));
  ccu_unit dut (.clock(clock), .arst_n(arst_n), .in_valid(in_valid), .instr_word(instr_word),
    .message_source_operand(msg), .crc_accumulator_operand(acc), .accumulator_index(idx),
    .crc_presence_flag(flag), .result_valid(result_valid), .result_crc(result_crc),
    .writeback_index(writeback_index), .reserved_instruction(reserved_instruction));
  function automatic logic [31:0] fold(logic [31:0] v, logic [31:0] m, int n, logic [31:0] p);
    v = v ^ (m & (32'hffffffff >> (32 - 8 * n)));
    for (int i = 0; i < 8 * n; i++)
      v = v[0] ? (v >> 1) ^ p : v >> 1;
    return v;
  endfunction
  task automatic issue();
    logic [31:0] exp;
    exp = fold(acc, msg, 1 << size, variant ? CCU_POLY_CASTAGNOLI : CCU_POLY_ETHERNET);
    in_valid = 1;
    @(negedge clock);
    in_valid = 0;
    fork
      @(negedge clock);
    join_none
    if (bad) `CHK({result_valid, reserved_instruction}, 2'b00)
    else if (!flag || size == 2'b11)
      `CHK({result_valid, reserved_instruction, result_crc}, {2'b01, last})
    else begin
      `CHK({result_valid, reserved_instruction, result_crc, writeback_index},
        {2'b10, exp, idx})
      last = exp;
      got = result_crc;
    end
    @(negedge clock);
  endtask
  task automatic report_and_stop();
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(negedge clock);
    arst_n = 1;
    for (int v = 0; v < 2; v++) begin
      variant = v;
      msg = 32'h80;
      issue();
    end
    variant = 1;
    acc = '1;
    for (int b = 0; b < 4; b++) begin
      msg = 32'h1234abcd >> (8 * b);
      issue();
      acc = got;
    end
    chain = got;
    size = 2'b10;
    msg = 32'h1234abcd;
    acc = '1;
    issue();
    `CHK(got, chain)
    repeat (300) begin
      {variant, size, regs, idx} = $random(seed);
      flag = ($random(seed) & 7) != 0;
      bad = ($random(seed) & 15) == 0;
      acc = $random(seed);
      msg = $random(seed);
      issue();
    end
    report_and_stop();
  end
endmodule
bind ccu_unit ccu_unit_assertions chk (.clock(clock), .arst_n(arst_n), .in_valid(in_valid),
  .instr_word(instr_word), .message_source_operand(message_source_operand),
  .crc_accumulator_operand(crc_accumulator_operand), .accumulator_index(accumulator_index),
  .crc_presence_flag(crc_presence_flag), .result_valid(result_valid),
  .result_crc(result_crc), .writeback_index(writeback_index),
  .reserved_instruction(reserved_instruction));
`default_nettype wire
